/* File: hw/xp_expander.sv */
// Purpose: eight-bit quasi-bidirectional port expander, two-wire slave
// Assumes: bus lines and port pins are asynchronous; two-flop synchronised
// Notes:   change interrupt is open-drain, active low
`timescale 1ns/100ps
module xp_expander (
  input  wire logic                       clock,
  input  wire logic                       nrst,
  xp_bus_if.expander                      bus,
  input  wire logic                       addr_sel_bit0,
  input  wire logic                       addr_sel_bit1,
  input  wire logic                       addr_sel_bit2,
  input  wire logic [xp_pkg::PORT_W-1:0]  pin_in,
  output logic      [xp_pkg::PORT_W-1:0]  pin_drive_low,
  output logic                            irq_o,
  output logic                            irq_oe
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AACK = 3'b010,
    S_WDAT = 3'b011,
    S_WACK = 3'b100,
    S_RDAT = 3'b101,
    S_RACK = 3'b110,
    S_SKIP = 3'b111
  } st_t;

  typedef struct packed {
    logic [1:0]                scl_s;
    logic [1:0]                sda_s;
    logic [1:0]                sel0_s;
    logic [1:0]                sel1_s;
    logic [1:0]                sel2_s;
    logic [xp_pkg::PORT_W-1:0] pin_s1;
    logic [xp_pkg::PORT_W-1:0] pin_s2;
    logic                      scl_d;
    logic                      sda_d;
    st_t                       st;
    logic [2:0]                bitn;
    logic [7:0]                sh;
    logic [7:0]                latch;
    logic [7:0]                ref_lvl;
    logic                      sda_low;
    logic                      irq_low;
    logic                      wr_strobe;
    logic                      byte_full;
  } state_t;

  state_t r;
  state_t next_r;
  logic   scl_rise;
  logic   scl_fall;
  logic   start_c;
  logic   stop_c;
  logic   addr_hit;

  // Decode conditions from synchronised lines only
  always_comb
  begin
    scl_rise  = r.scl_s[1] && !r.scl_d;
    scl_fall  = !r.scl_s[1] && r.scl_d;
    start_c   = r.scl_s[1] && r.scl_d && r.sda_d && !r.sda_s[1];
    stop_c    = r.scl_s[1] && r.scl_d && !r.sda_d && r.sda_s[1];
    addr_hit  = r.sh[7:1] == {xp_pkg::ADDR_PREFIX, r.sel2_s[1], r.sel1_s[1],
                              r.sel0_s[1]};
    next_r    = r;
    next_r.scl_s     = {r.scl_s[0], bus.scl};
    next_r.sda_s     = {r.sda_s[0], bus.sda};
    next_r.sel0_s    = {r.sel0_s[0], addr_sel_bit0};
    next_r.sel1_s    = {r.sel1_s[0], addr_sel_bit1};
    next_r.sel2_s    = {r.sel2_s[0], addr_sel_bit2};
    next_r.pin_s1    = pin_in;
    next_r.pin_s2    = r.pin_s1;
    next_r.scl_d     = r.scl_s[1];
    next_r.sda_d     = r.sda_s[1];
    next_r.wr_strobe = 1'b0;

    // Byte engine; sampling on rising clock, driving on falling
    if (stop_c)
    begin
      next_r.st      = S_IDLE;
      next_r.sda_low = 1'b0;
    end
    else if (start_c)
    begin
      next_r.st        = S_ADDR;
      next_r.bitn      = xp_pkg::BIT_FIRST;
      next_r.byte_full = 1'b0;
      next_r.sda_low   = 1'b0;
    end
    else
    begin
      unique case (r.st)
        S_IDLE, S_SKIP: ;
        S_ADDR, S_WDAT:
          if (scl_rise)
          begin
            next_r.sh        = {r.sh[6:0], r.sda_s[1]};
            next_r.bitn      = r.bitn + 3'h1;
            next_r.byte_full = (r.bitn == xp_pkg::BIT_LAST);
          end
          // Byte counted by rises, so the start's own clock fall is ignored
          else if (scl_fall && r.byte_full)
          begin
            next_r.byte_full = 1'b0;
            if (r.st == S_WDAT)
            begin
              next_r.st      = S_WACK;
              next_r.sda_low = 1'b1;
            end
            else if (addr_hit)
            begin
              next_r.st      = S_AACK;
              next_r.sda_low = 1'b1;
            end
            else
              next_r.st = S_SKIP;
          end
        S_AACK:
          if (scl_fall)
          begin
            if (r.sh[0] == xp_pkg::DIR_READ)
            begin
              next_r.st      = S_RDAT;
              next_r.sh      = r.pin_s2;
              next_r.sda_low = !r.pin_s2[7];
              next_r.ref_lvl = r.pin_s2;
            end
            else
            begin
              next_r.st      = S_WDAT;
              next_r.sda_low = 1'b0;
            end
          end
          else if (scl_rise && r.sh[0] == xp_pkg::DIR_WRITE)
            next_r.ref_lvl = r.pin_s2;
        S_WACK:
          if (scl_rise)
          begin
            next_r.latch     = r.sh;
            next_r.wr_strobe = 1'b1;
          end
          else if (scl_fall)
          begin
            next_r.st      = S_WDAT;
            next_r.sda_low = 1'b0;
            next_r.ref_lvl = r.pin_s2;
          end
        S_RDAT:
          if (scl_rise)
            next_r.bitn = r.bitn + 3'h1;
          else if (scl_fall)
          begin
            if (r.bitn == xp_pkg::BIT_FIRST)
            begin
              next_r.st      = S_RACK;
              next_r.sda_low = 1'b0;
            end
            else
            begin
              next_r.sh      = {r.sh[6:0], 1'b1};
              next_r.sda_low = !r.sh[6];
            end
          end
        S_RACK:
          if (scl_rise && r.sda_s[1])
            next_r.st = S_SKIP;
          else if (scl_fall)
          begin
            next_r.st      = S_RDAT;
            next_r.sh      = r.pin_s2;
            next_r.sda_low = !r.pin_s2[7];
            next_r.ref_lvl = r.pin_s2;
          end
        default: next_r.st = S_IDLE;
      endcase
    end

    // Change watch against the reference; an access recaptures it, so the
    // interrupt drops that cycle and a coinciding change shows one cycle later
    next_r.irq_low = (r.pin_s2 != next_r.ref_lvl);
  end

  // Single register bank; reset leaves port released high
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r         <= '0;
      r.scl_s   <= 2'h3;
      r.sda_s   <= 2'h3;
      r.scl_d   <= 1'b1;
      r.sda_d   <= 1'b1;
      r.st      <= S_IDLE;
      r.pin_s1  <= xp_pkg::PORT_RESET;                             // No false change at release
      r.pin_s2  <= xp_pkg::PORT_RESET;
      r.latch   <= xp_pkg::PORT_RESET;
      r.ref_lvl <= xp_pkg::PORT_RESET;
    end
    else
      r <= next_r;
  end

  assign bus.sda_o_s   = 1'b0;
  assign bus.sda_oe_s  = r.sda_low;
  assign pin_drive_low = ~r.latch;
  assign irq_o         = 1'b0;
  assign irq_oe        = r.irq_low;
endmodule : xp_expander

/* File: hw/xp_master.sv */
// Purpose: simple two-wire master that writes or reads the expander port
// Assumes: bus clock made here by a divider; no clock stretching
// Notes:   one byte per request; read ends with a withheld acknowledge
`timescale 1ns/100ps
module xp_master (
  input  wire logic       clock,
  input  wire logic       nrst,
  xp_bus_if.master        bus,
  input  wire logic       req,
  input  wire logic       req_read,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            busy,
  output logic            done,
  output logic            nacked,
  output logic [7:0]      rd_data
);
  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BYTE  = 3'b010,
    M_ACK   = 3'b011,
    M_STOP  = 3'b100,
    M_END   = 3'b101
  } mst_t;

  typedef struct packed {
    mst_t       st;
    logic [9:0] cnt;
    logic [1:0] ph;
    logic [2:0] bitn;
    logic       data_phase;
    logic       rd;
    logic [7:0] sh;
    logic [7:0] wdat;
    logic       scl;
    logic       sda;
    logic       busy;
    logic       done;
    logic       nacked;
    logic [7:0] rd_data;
    logic [1:0] sda_s;
  } mstate_t;

  mstate_t r;
  mstate_t next_r;
  logic    tick;

  // Quarter-period ticks drive SCL phases
  always_comb
  begin
    next_r       = r;
    next_r.sda_s = {r.sda_s[0], bus.sda};
    next_r.done  = 1'b0;
    tick         = r.cnt == xp_pkg::CNT_ZERO;
    next_r.cnt   = tick ? xp_pkg::QUARTER_CNT : r.cnt - 10'h001;
    if (r.st == M_IDLE)
    begin
      next_r.cnt = xp_pkg::QUARTER_CNT;
      if (req && bus.scl && r.sda_s[1])
      begin
        next_r.st   = M_START;
        next_r.busy = 1'b1;
        next_r.rd   = req_read;
        next_r.sh   = {req_addr, req_read};
        next_r.wdat = req_data;
        next_r.ph   = 2'h0;
        next_r.data_phase = 1'b0;
        next_r.nacked     = 1'b0;
      end
    end
    else if (tick)
    begin
      next_r.ph = r.ph + 2'h1;
      unique case (r.st)
        M_IDLE: ;
        M_START:
          if (r.ph == 2'h1)
            next_r.sda = 1'b0;
          else if (r.ph == 2'h3)
          begin
            next_r.scl  = 1'b0;
            next_r.st   = M_BYTE;
            next_r.bitn = xp_pkg::BIT_FIRST;
          end
        M_BYTE:
          unique case (r.ph)
            2'h0: next_r.sda = (r.data_phase && r.rd) ? 1'b1 : r.sh[7];
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.sh  = {r.sh[6:0], r.sda_s[1]};
            2'h3:
            begin
              next_r.scl  = 1'b0;
              next_r.bitn = r.bitn + 3'h1;
              if (r.bitn == xp_pkg::BIT_LAST)
                next_r.st = M_ACK;
            end
          endcase
        M_ACK:
          unique case (r.ph)
            2'h0: next_r.sda = !(r.data_phase && r.rd) ? 1'b1 : 1'b1;
            2'h1: next_r.scl = 1'b1;
            2'h2:
              if (!r.data_phase && r.sda_s[1])
                next_r.nacked = 1'b1;
            2'h3:
            begin
              next_r.scl = 1'b0;
              if (r.data_phase || r.nacked)
                next_r.st = M_STOP;
              else
              begin
                next_r.st         = M_BYTE;
                next_r.data_phase = 1'b1;
                next_r.sh         = r.rd ? r.sh : r.wdat;
                if (r.rd)
                  next_r.rd_data = r.sh;
              end
              if (r.data_phase && r.rd)
                next_r.rd_data = r.sh;
            end
          endcase
        M_STOP:
          unique case (r.ph)
            2'h0: next_r.sda = 1'b0;
            2'h1: next_r.scl = 1'b1;
            2'h2: next_r.sda = 1'b1;
            2'h3: next_r.st  = M_END;
          endcase
        M_END:
        begin
          next_r.st   = M_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
        default: next_r.st = M_IDLE;
      endcase
    end
  end

  // Registers; bus released high at reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r       <= '0;
      r.st    <= M_IDLE;
      r.scl   <= 1'b1;
      r.sda   <= 1'b1;
      r.sda_s <= 2'h3;
    end
    else
      r <= next_r;
  end

  // Master acknowledges nothing in a one-byte read: sda stays released
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = !r.scl;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = !r.sda;
  assign busy         = r.busy;
  assign done         = r.done;
  assign nacked       = r.nacked;
  assign rd_data      = r.rd_data;
endmodule : xp_master

/* File: inc/xp_bus_if.sv */
// Purpose: two-wire bus wires between master end and expander end
// Assumes: open-drain lines with pull-ups resolved here
// Notes:   a line is low when any party enables its driver
`timescale 1ns/100ps
interface xp_bus_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;

  // Pull-up wins unless someone drives low
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));

  modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m,
                  input scl, input sda);
  modport expander (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface : xp_bus_if

/* File: inc/xp_pkg.sv */
// Purpose: shared constants for the two-wire port expander
// Assumes: 100 MHz system clock on both ends
// Notes:   link clock is made by the master end through a divider
package xp_pkg;
  localparam int          PORT_W        = 8;
  localparam logic [3:0]  ADDR_PREFIX   = 4'h4;     // Fixed address prefix
  localparam logic [7:0]  PORT_RESET    = 8'hff;    // All pins high after reset
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;
  localparam int          CLK_MHZ       = 100;
  localparam int          SCL_PERIOD_NS = 10000;    // 100 kHz bus clock
  localparam int          QUARTER_CYC   = SCL_PERIOD_NS * CLK_MHZ / 4000;
  localparam logic [9:0]  QUARTER_CNT   = 10'(QUARTER_CYC - 1);
  localparam logic [9:0]  CNT_ZERO      = 10'h000;
  localparam logic        DIR_WRITE     = 1'b0;
  localparam logic        DIR_READ      = 1'b1;
endpackage : xp_pkg

/* File: verif/i2c_port_expander_change_irq_tb_top.sv */
// Purpose: bench for master and expander joined over the link
// Assumes: 100 MHz clock; one byte per master request
// Notes:   pin level is outside level and expander pull-down
`timescale 1ns/100ps
module i2c_port_expander_change_irq_tb_top;
  localparam logic [6:0] DEV = {xp_pkg::ADDR_PREFIX, 3'h2};
  logic       clock;
  logic       nrst;
  logic       req;
  logic       req_read;
  logic [6:0] req_addr;
  logic [7:0] req_data;
  logic       busy;
  logic       done;
  logic       nacked;
  logic [7:0] rd_data;
  logic [2:0] addr_sel;
  logic [7:0] ext;
  logic [7:0] pin_drive_low;
  logic       irq_o;
  logic       irq_oe;
  wire  [7:0] pin_in;
  int         failures;
  int         tests_run;

  xp_bus_if bus ();
  // Pin is low when the outside or the expander pulls it
  assign pin_in = ext & ~pin_drive_low;

  xp_master i_xp_master (.clock(clock), .nrst(nrst), .bus(bus), .req(req),
    .req_read(req_read), .req_addr(req_addr), .req_data(req_data), .busy(busy),
    .done(done), .nacked(nacked), .rd_data(rd_data));
  xp_expander i_xp_expander (.clock(clock), .nrst(nrst), .bus(bus),
    .addr_sel_bit0(addr_sel[0]), .addr_sel_bit1(addr_sel[1]),
    .addr_sel_bit2(addr_sel[2]), .pin_in(pin_in),
    .pin_drive_low(pin_drive_low), .irq_o(irq_o), .irq_oe(irq_oe));
  xp_link_properties i_xp_link_properties (.clock(clock), .nrst(nrst),
    .scl(bus.scl), .sda(bus.sda), .sda_oe_s(bus.sda_oe_s), .irq_oe(irq_oe),
    .pin_in(pin_in));

  // Free-running system clock
  always #5 clock = ~clock;

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done;
    $display("counts: %0d compared, %0d mismatched", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Hold the request until taken, then wait for completion
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
    int n;
    req_read = rd;
    req_addr = a;
    req_data = d;
    req = 1'b1;
    for (n = 0; n < 20 && busy !== 1'b1; n++)
      tick(1);
    req = 1'b0;
    if (busy !== 1'b1)
    begin
      failures++;
      test_done();
    end
    for (n = 0; n < 40000 && done !== 1'b1; n++)
      tick(1);
    if (n == 40000)
    begin
      failures++;
      test_done();
    end
    tick(10);
  endtask : xfer

  task automatic t_reset;
    tick(10);
    cmp({7'h00, irq_oe}, 8'h01);
    cmp({7'h00, irq_o}, 8'h00);
    cmp({7'h00, busy}, 8'h00);
    cmp(pin_drive_low, 8'h00);
    $display("reset test ended");
  endtask : t_reset

  task automatic t_read(input logic [7:0] exp);
    xfer(1'b1, DEV, 8'h00);
    cmp({7'h00, nacked}, 8'h00);
    cmp(rd_data, exp);
    cmp({7'h00, irq_oe}, 8'h00);
    $display("read test ended");
  endtask : t_read

  // Falling edge, restore, then rising edge
  task automatic t_change;
    ext = 8'hf6;
    tick(10);
    cmp({7'h00, irq_oe}, 8'h01);
    ext = 8'hf7;
    tick(10);
    cmp({7'h00, irq_oe}, 8'h00);
    ext = 8'hff;
    tick(10);
    cmp({7'h00, irq_oe}, 8'h01);
    $display("change test ended");
  endtask : t_change

  // Inputs written high, tied pair switched together
  task automatic t_write;
    xfer(1'b0, DEV, 8'h3f);
    cmp({7'h00, nacked}, 8'h00);
    cmp(pin_drive_low, 8'hc0);
    cmp({7'h00, irq_oe}, 8'h00);
    ext = 8'hfe;
    tick(10);
    cmp({7'h00, irq_oe}, 8'h01);
    $display("write test ended");
  endtask : t_write

  // Change judged against what the last read saw; foreign access keeps it
  task automatic t_wrong;
    ext = 8'hff;
    addr_sel = 3'h5;
    tick(10);
    cmp({7'h00, irq_oe}, 8'h01);
    xfer(1'b0, DEV, 8'h00);
    cmp({7'h00, nacked}, 8'h01);
    cmp(pin_drive_low, 8'hc0);
    cmp({7'h00, irq_oe}, 8'h01);
    $display("address test ended");
  endtask : t_wrong

  // Main sequence; bit 3 held low through reset
  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    req = 1'b0;
    req_read = 1'b0;
    req_addr = 7'h00;
    req_data = 8'h00;
    addr_sel = 3'h2;
    ext = 8'hf7;
    failures = 0;
    tests_run = 0;
    tick(3);
    nrst = 1'b1;
    t_reset();
    t_read(8'hf7);
    t_change();
    t_write();
    t_read(8'h3e);
    t_wrong();
    test_done();
  end
endmodule : i2c_port_expander_change_irq_tb_top

/* File: verif/xp_link_properties.sv */
// Purpose: protocol and interrupt checks on the two-wire link
// Assumes: one clock domain, async active-low reset
// Notes:   watches resolved wires, expander driver and interrupt
`timescale 1ns/100ps
module xp_link_properties (
  input wire logic                      clock,
  input wire logic                      nrst,
  input wire logic                      scl,
  input wire logic                      sda,
  input wire logic                      sda_oe_s,
  input wire logic                      irq_oe,
  input wire logic [xp_pkg::PORT_W-1:0] pin_in
);
  logic                      scl_q;
  logic                      sda_q;
  logic [xp_pkg::PORT_W-1:0] pin_q;
  logic [3:0]                bits;
  logic                      nak;
  logic                      chg;
  logic                      ack;
  logic                      start_w;
  logic                      stop_w;

  // Start and stop taken from wire edges while the clock is high
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w  = scl && scl_q && !sda_q && sda;

  // Bit slot, withheld acknowledge and activity since last start
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pin_q <= '1;
      bits  <= 4'h0;
      nak   <= 1'b0;
      chg   <= 1'b0;
      ack   <= 1'b0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      pin_q <= pin_in;
      if (start_w)
      begin
        bits <= 4'h0;
        nak  <= 1'b0;
        chg  <= 1'b0;
        ack  <= 1'b0;
      end
      else
      begin
        if (scl && !scl_q)
          bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
        if (scl && !scl_q && bits == 4'h8 && sda)
          nak <= 1'b1;
        if (pin_in != pin_q)
          chg <= 1'b1;
        if (sda_oe_s)
          ack <= 1'b1;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  start_idle_a: assert property (start_w |-> $past(scl, 2) && $past(sda, 2))
    else $error("start without idle bus");
  // The stop's own clock pulse is the one rise after the last acknowledge
  byte_frame_a: assert property (stop_w |-> bits == 4'h1)
    else $error("stop inside a byte");
  slave_hold_a: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
    else $error("expander data moved while clock high");
  drive_edge_a: assert property ($rose(sda_oe_s) |-> !scl)
    else $error("expander drive began with clock high");
  nack_release_a: assert property (nak |-> !sda_oe_s)
    else $error("expander drives after withheld acknowledge");
  irq_rise_a: assert property ($changed(pin_in) && scl && sda && !irq_oe
    |-> ##[1:6] irq_oe)
    else $error("pin change gave no interrupt");
  read_clear_a: assert property (stop_w && ack && !chg |-> !irq_oe)
    else $error("interrupt kept after access");
  irq_fall_a: assert property ($fell(irq_oe) |-> chg || ack)
    else $error("interrupt dropped without cause");

  cover property (start_w);
  cover property (nak);
  cover property ($rose(irq_oe));
endmodule : xp_link_properties
